/* core/mmd_regs.vh */
// What this block does
// - one 4.5KB RAM serves fetch, code reads, xdata reads and xdata writes
// - 12KB ROM supplies fetches only; data reads of it return undefined
// - nonvolatile arrays are decoded into no processor address space
// - 256 bytes internal RAM; lower half direct and indirect
// - bytes 0x00-0x1F are four banks of eight registers, one active
// - active bank comes from status word bits 4 and 3
// - indirect accesses take their pointer from register 0 or 1 of active bank
// - bytes 0x20-0x2F hold 128 bits, bit address = (byte-0x20)*8+bit
// - bit versus byte access chosen only by operand type
// - above 0x7F direct goes to special registers, indirect to upper RAM
// - stack pointer marks last used byte; push writes pointer+1 then increments
// - stack pointer at special address 0x81, reset 0x07, first push at 0x08
// - special registers ending in 0 or 8 take bit access; others byte only
// - xdata-mapped registers answer only external data moves, like plain memory
// - wide xdata registers store most significant byte at the lowest address
// - 16 rewritable cell bytes readable at xdata 0x4040-0x404F
// - writes never alter rewritable cell content, window writes are dropped
// - one-time store cannot be programmed by any processor write
// - programming a 16-byte image cycles only bits that change
// - xdata-mapped register block occupies 256 bytes
`ifndef MMD_REGS_VH
`define MMD_REGS_VH
`define MMD_RAM_BASE 16'h0000
`define MMD_RAM_LAST 16'h11FF
`define MMD_XDATA_MAPPED_REGISTERS_BASE 16'h4000
`define MMD_XDATA_MAPPED_REGISTERS_LAST 16'h40FF
`define MMD_WIN_BASE 16'h4040
`define MMD_WIN_LAST 16'h404F
`define MMD_ROM_BASE 16'h8000
`define MMD_ROM_LAST 16'hAFFF
`define MMD_SP_ADDR 8'h81
`define MMD_PSW_ADDR 8'hD0
`define MMD_SP_RESET 8'h07
`define MMD_BIT_BYTE_BASE 8'h20
`define MMD_UPPER_BASE 8'h80
`define MMD_UNDEF_BYTE 8'hFF
`define MMD_BANK_HI 4
`define MMD_BANK_LO 3
`define MMD_BITSFR_MASK 8'h07
`endif

/* core/mmd_iram.v */
`timescale 1ns/1ps
`default_nettype none
// internal data RAM, upper and lower halves, two read ports and one write port
module mmd_iram #(
    parameter DEPTH = 256
) (
    input wire clock,
    input wire [7:0] rdAddr,
    output wire [7:0] rdData,
    input wire [7:0] rdAddr2,
    output wire [7:0] rdData2,
    input wire wrEn,
    input wire [7:0] wrAddr,
    input wire [7:0] wrData
);
    reg [7:0] mem [0:DEPTH-1];

    // asynchronous reads so decoder can resolve pointers in one cycle
    assign rdData = mem[rdAddr];
    assign rdData2 = mem[rdAddr2];

    // contents are not reset, lost at power cycle anyway
    always @(posedge clock) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end
endmodule // mmd_iram
`default_nettype wire

/* core/mmd_decoder.v */
`timescale 1ns/1ps
`default_nettype none
`include "mmd_regs.vh"
// memory map decoder: code/xdata space and internal data space
module mmd_decoder #(
    parameter RAM_WORDS = 4608,
    parameter WIN_BYTES = 16,
    parameter ROM_WORDS = 12288
) (
    input wire clock,
    input wire rst,
    // code / xdata request from the core
    input wire extReq,
    input wire extIsFetch,
    input wire extIsCodeRd,
    input wire extWr,
    input wire [15:0] extAddr,
    input wire [7:0] extWrData,
    output reg [7:0] extRdData,
    output reg extDone,
    // rom contents supplied from outside
    output wire [13:0] romAddr,
    input wire [7:0] romData,
    // xdata-mapped register block, other than the cell window
    output wire xregSel,
    output wire [7:0] xregAddr,
    input wire [7:0] xregRdData,
    // current rewritable cell image, byte 0 in the low bits
    // image is only read here; change-only programming lives in the programmer
    input wire [127:0] cellImage,
    // internal data request
    input wire intReq,
    input wire intWr,
    input wire intIndirect,
    input wire intBit,
    input wire intRegPtr,
    input wire intPtrSel,
    input wire [7:0] intAddr,
    input wire [7:0] intWrData,
    input wire intWrBit,
    output reg [7:0] intRdData,
    output reg intRdBit,
    output reg intDone,
    output wire sfrSel,
    output wire [7:0] sfrAddr,
    input wire [7:0] sfrRdData,
    output reg sfrBitBad,
    // stack operations
    input wire push,
    input wire pop,
    input wire [7:0] pushData,
    output wire [7:0] stackTopPointer,
    output wire [1:0] activeBank,
    output wire [7:0] programStatusWord
);
    reg [7:0] ramMem [0:RAM_WORDS-1];
    reg [7:0] spR;
    reg [7:0] spNxt;
    reg [7:0] pswR;
    reg [7:0] pswNxt;
    reg [7:0] pushByte;

    // address range test used for every region
    function inRange;
        input [15:0] a;
        input [15:0] lo;
        input [15:0] hi;
        begin
            inRange = (a >= lo) && (a <= hi);
        end
    endfunction

    // bit address to byte address in the bit area or the special space
    function [7:0] bitByte;
        input [7:0] b;
        begin
            if (b[7]) begin
                bitByte = {b[7:3], 3'b000};
            end else begin
                bitByte = `MMD_BIT_BYTE_BASE + {4'h0, b[6:3]};
            end
        end
    endfunction

    wire hitRam = inRange(extAddr, `MMD_RAM_BASE, `MMD_RAM_LAST);
    wire hitWin = inRange(extAddr, `MMD_WIN_BASE, `MMD_WIN_LAST);
    wire hitXreg = inRange(extAddr, `MMD_XDATA_MAPPED_REGISTERS_BASE, `MMD_XDATA_MAPPED_REGISTERS_LAST);
    wire hitRom = inRange(extAddr, `MMD_ROM_BASE, `MMD_ROM_LAST);
    wire [15:0] ramOff = extAddr - `MMD_RAM_BASE;
    wire [15:0] romOff = extAddr - `MMD_ROM_BASE;
    wire [15:0] winOff = extAddr - `MMD_WIN_BASE;
    wire [15:0] xregOff = extAddr - `MMD_XDATA_MAPPED_REGISTERS_BASE;
    wire isXdata = !extIsFetch && !extIsCodeRd;

    assign romAddr = romOff[13:0];
    // register block reached only by external data moves
    assign xregSel = extReq && isXdata && hitXreg && !hitWin;
    assign xregAddr = xregOff[7:0];

    // external read mux; nonvolatile store has no decode here
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            extRdData <= 8'h00;
            extDone <= 1'b0;
        end else begin
            extDone <= extReq;
            if (extReq && !extWr) begin
                if (hitRam) begin
                    extRdData <= ramMem[ramOff[12:0]];
                end else if (hitRom && extIsFetch) begin
                    extRdData <= romData;
                end else if (hitWin && isXdata) begin
                    // byte i of the window is cell byte i; byte 0 in the low bits
                    extRdData <= cellImage[{winOff[3:0], 3'b000} +: 8];
                end else if (xregSel) begin
                    extRdData <= xregRdData;
                end else begin
                    extRdData <= `MMD_UNDEF_BYTE;
                end
            end
        end
    end

    // ram writes only; window, rom, unmapped and store writes dropped
    always @(posedge clock) begin
        if (extReq && extWr && isXdata && hitRam) begin
            ramMem[ramOff[12:0]] <= extWrData;
        end
    end

    // ---- internal data space ----
    assign activeBank = {pswR[`MMD_BANK_HI], pswR[`MMD_BANK_LO]};
    assign stackTopPointer = spR;
    assign programStatusWord = pswR;

    // pointer register address for the active bank
    wire [7:0] ptrLoc = {3'b000, activeBank, 2'b00, intPtrSel};
    wire [7:0] ptrVal;
    wire [7:0] bitBase = bitByte(intAddr);
    wire [7:0] regLoc = {3'b000, activeBank, intAddr[2:0]};
    reg [7:0] effAddr;
    reg toSfr;

    // effective address and target space
    always @* begin
        effAddr = intAddr;
        toSfr = 1'b0;
        if (push) begin
            effAddr = spR + 8'h01;
        end else if (pop) begin
            effAddr = spR;
        end else if (intIndirect) begin
            effAddr = ptrVal;
        end else if (intRegPtr) begin
            effAddr = regLoc;
        end else if (intBit) begin
            effAddr = bitBase;
            toSfr = intAddr[7];
        end else begin
            toSfr = intAddr[7];
        end
    end

    wire [7:0] iramRd;
    wire iramWr = (intReq && intWr && !toSfr) || push;
    assign sfrSel = intReq && toSfr;
    assign sfrAddr = effAddr;
    wire sfrSp = toSfr && (effAddr == `MMD_SP_ADDR);
    wire sfrPsw = toSfr && (effAddr == `MMD_PSW_ADDR);
    wire sfrBitOk = (effAddr & `MMD_BITSFR_MASK) == 8'h00;
    wire [7:0] curByte = sfrSp ? spR : (sfrPsw ? pswR : (toSfr ? sfrRdData : iramRd));
    wire [7:0] bitMask = 8'h01 << intAddr[2:0];
    wire [7:0] bitMerged = intWrBit ? (curByte | bitMask) : (curByte & ~bitMask);
    wire [7:0] wrVal = intBit ? bitMerged : intWrData;

    always @* begin
        pushByte = pushData;
        if (!push) begin
            pushByte = wrVal;
        end
    end

    mmd_iram #(
        .DEPTH(256)
    ) uIram (
        .clock(clock),
        .rdAddr(effAddr),
        .rdData(iramRd),
        .rdAddr2(ptrLoc),
        .rdData2(ptrVal),
        .wrEn(iramWr),
        .wrAddr(effAddr),
        .wrData(pushByte)
    );

    // stack pointer and status word next values
    always @* begin
        spNxt = spR;
        pswNxt = pswR;
        if (push) begin
            spNxt = spR + 8'h01;
        end else if (pop) begin
            spNxt = spR - 8'h01;
        end else if (intReq && intWr && sfrSp && (!intBit || sfrBitOk)) begin
            spNxt = wrVal;
        end else if (intReq && intWr && sfrPsw && (!intBit || sfrBitOk)) begin
            pswNxt = wrVal;
        end
    end

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            spR <= `MMD_SP_RESET;
            pswR <= 8'h00;
        end else begin
            spR <= spNxt;
            pswR <= pswNxt;
        end
    end

    // internal read result registered, one cycle after request
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            intRdData <= 8'h00;
            intRdBit <= 1'b0;
            intDone <= 1'b0;
            sfrBitBad <= 1'b0;
        end else begin
            intDone <= intReq || push || pop;
            sfrBitBad <= intReq && intBit && toSfr && !sfrBitOk;
            if ((intReq && !intWr) || pop) begin
                intRdData <= curByte;
                intRdBit <= curByte[intAddr[2:0]] && (!toSfr || !intBit || sfrBitOk);
            end
        end
    end
endmodule // mmd_decoder
`default_nettype wire

/* verification/mmd_decoder_props.sv */
`timescale 1ns/1ps
`default_nettype none
// port checker for the memory map decoder
module mmd_decoder_props (
    input wire clock,
    input wire rst,
    input wire extReq,
    input wire extIsFetch,
    input wire extIsCodeRd,
    input wire extWr,
    input wire [15:0] extAddr,
    input wire [7:0] extRdData,
    input wire extDone,
    input wire [127:0] cellImage,
    input wire xregSel,
    input wire push,
    input wire pop,
    input wire [7:0] stackTopPointer,
    input wire [1:0] activeBank,
    input wire [7:0] programStatusWord
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // data reads, code or xdata move
    wire dataRd = extReq && !extIsFetch && !extWr;
    wire inWin = extAddr[15:4] == 12'h0404;
    ext_done_a: assert property (extReq |=> extDone)
        else $error("request without done");
    rom_undef_a: assert property (dataRd && extAddr >= 16'h8000 && extAddr <= 16'hAFFF |=> extRdData == 8'hFF)
        else $error("rom data read leaked");
    cell_read_a: assert property (dataRd && !extIsCodeRd && inWin |=> extRdData == cellImage[8*$past(extAddr[3:0]) +: 8])
        else $error("window byte wrong");
    sp_push_a: assert property (push && !pop |=> stackTopPointer == $past(stackTopPointer) + 8'h01)
        else $error("push did not bump pointer");
    sp_pop_a: assert property (pop && !push |=> stackTopPointer == $past(stackTopPointer) - 8'h01)
        else $error("pop did not drop pointer");
    bank_map_a: assert property (activeBank == programStatusWord[4:3])
        else $error("bank not from status word");
    xdata_mapped_registers_move_a: assert property (extIsFetch || extIsCodeRd |-> !xregSel)
        else $error("xdata_mapped_registers hit by code access");
    window_out_a: assert property (inWin |-> !xregSel)
        else $error("window routed to xdata_mapped_registers");
    xdata_mapped_registers_span_a: assert property (dataRd && !extIsCodeRd && extAddr[15:8] == 8'h40 && !inWin |-> xregSel)
        else $error("xdata_mapped_registers block not selected");
    cover property (push);
    cover property (dataRd && extAddr[15] == 1'b1);
    cover property (dataRd && inWin);
endmodule // mmd_decoder_props
bind mmd_decoder mmd_decoder_props i_props (.*);
`default_nettype wire

/* verification/mmd_far_model.sv */
`timescale 1ns/1ps
`default_nettype none
// rom, xdata_mapped_registers, sfr and cell image behind the decoder
module mmd_far_model (
    input wire logic [13:0] romAddr,
    input wire logic xregSel,
    input wire logic [7:0] xregAddr,
    input wire logic sfrSel,
    input wire logic [7:0] sfrAddr,
    output logic [7:0] romData,
    output logic [7:0] xregRdData,
    output logic [7:0] sfrRdData,
    output logic [127:0] cellImage
);
    // deselected buses show the inverse so stale values never match
    assign romData = romAddr[7:0] ^ 8'h5C;
    assign xregRdData = xregSel ? xregAddr ^ 8'h3C : ~(xregAddr ^ 8'h3C);
    // every special address answers here; the bench reads 0x90 and writes the status word at 0xD0
    assign sfrRdData = sfrSel ? sfrAddr + 8'h11 : ~(sfrAddr + 8'h11);
    // fixed image, no write path at all
    assign cellImage = 128'hCFCE_CDCC_CBCA_C9C8_C7C6_C5C4_C3C2_C1C0;
endmodule // mmd_far_model
`default_nettype wire

/* verification/mmd_decoder_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module mmd_decoder_tb;
    typedef struct {logic [1:0] k; logic w; logic [15:0] a; logic [7:0] d;} mmd_row_t;
    logic clock = 0, rst = 1, extReq = 0, extIsFetch = 0, extIsCodeRd = 0, extWr = 0, push = 0, pop = 0;
    logic intReq = 0, intWr = 0, intIndirect = 0, intBit = 0, intRegPtr = 0, intPtrSel = 0, intWrBit = 0;
    logic [15:0] extAddr = '0;
    logic [7:0] extWrData = '0, intAddr = '0, intWrData = '0, pushData = '0, got;
    logic [7:0] romData, xregRdData, sfrRdData, extRdData, xregAddr, intRdData, sfrAddr;
    logic [7:0] stackTopPointer, programStatusWord;
    logic [13:0] romAddr;
    logic [127:0] cellImage;
    logic [1:0] activeBank;
    logic extDone, xregSel, intRdBit, intDone, sfrSel, sfrBitBad;
    int errors = 0, comparisons = 0, cycles = 0;
    // k: 1 fetch, 2 code read; d is write data or expected read
    mmd_row_t rows [14] = '{
        '{2'h0, 1'b1, 16'h0000, 8'hA5}, '{2'h0, 1'b0, 16'h0000, 8'hA5},
        '{2'h1, 1'b0, 16'h0000, 8'hA5}, '{2'h2, 1'b0, 16'h0000, 8'hA5},
        '{2'h0, 1'b1, 16'h11FF, 8'h5A}, '{2'h2, 1'b0, 16'h11FF, 8'h5A},
        '{2'h1, 1'b0, 16'h8003, 8'h5F}, '{2'h2, 1'b0, 16'h8003, 8'hFF},
        '{2'h0, 1'b0, 16'hAFFF, 8'hFF}, '{2'h0, 1'b1, 16'h4041, 8'h00},
        '{2'h0, 1'b0, 16'h4041, 8'hC1}, '{2'h0, 1'b0, 16'h4010, 8'h2C},
        '{2'h0, 1'b1, 16'h2000, 8'h77}, '{2'h0, 1'b0, 16'h2000, 8'hFF}};
    mmd_decoder i_dut (.*);
    mmd_far_model i_far (.*);
    initial forever #5 clock = ~clock;
    task automatic check(input logic [7:0] g, input logic [7:0] e, input string m);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    task automatic ext(input logic [1:0] k, input logic w, input logic [15:0] a, input logic [7:0] d);
        {extIsCodeRd, extIsFetch, extWr, extAddr, extWrData} = {k, w, a, d};
        extReq = 1;
        @(negedge clock);
        extReq = 0;
        got = extRdData;
    endtask
    // flags: write, indirect, bit, register, pointer R1, bit value
    task automatic iop(input logic [5:0] f, input logic [7:0] a, input logic [7:0] d);
        {intWr, intIndirect, intBit, intRegPtr, intPtrSel, intWrBit} = f;
        {intAddr, intWrData} = {a, d};
        intReq = 1;
        @(negedge clock);
        intReq = 0;
    endtask
    task automatic stk(input logic u, input logic [7:0] d);
        {push, pop, pushData} = {u, !u, d};
        @(negedge clock);
        {push, pop} = 2'b00;
    endtask
    task automatic complete_run;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // hang guard
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            errors++;
            complete_run;
        end
    end
    initial begin
        repeat (6) @(negedge clock);
        rst = 0;
        check(stackTopPointer, 8'h07, "sp reset");
        foreach (rows[i]) begin
            ext(rows[i].k, rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) check(got, rows[i].d, "ext row");
        end
        $display("ext table done");
        stk(1'b1, 8'h3E);
        check(stackTopPointer, 8'h08, "sp push");
        iop(6'h00, 8'h08, 8'h00);
        check(intRdData, 8'h3E, "pushed byte");
        iop(6'h20, 8'hD0, 8'h08);
        check({6'h00, activeBank}, 8'h01, "bank");
        iop(6'h04, 8'h00, 8'h00);
        check(intRdData, 8'h3E, "bank1 R0");
        iop(6'h20, 8'h3E, 8'h9D);
        iop(6'h10, 8'h00, 8'h00);
        check(intRdData, 8'h9D, "via R0");
        iop(6'h20, 8'h09, 8'h90);
        iop(6'h32, 8'h00, 8'h6B);
        iop(6'h12, 8'h00, 8'h00);
        check(intRdData, 8'h6B, "upper ram");
        iop(6'h00, 8'h90, 8'h00);
        check(intRdData, 8'hA1, "sfr direct");
        iop(6'h20, 8'h22, 8'h08);
        iop(6'h08, 8'h13, 8'h00);
        check({7'h00, intRdBit}, 8'h01, "bit set");
        iop(6'h08, 8'h12, 8'h00);
        check({7'h00, intRdBit}, 8'h00, "bit clear");
        stk(1'b0, 8'h00);
        check(intRdData, 8'h3E, "pop data");
        check(stackTopPointer, 8'h07, "sp pop");
        $display("internal done");
        // mid-run reset: pointer and status word return to reset values
        stk(1'b1, 8'h44);
        rst = 1;
        @(negedge clock);
        rst = 0;
        check(stackTopPointer, 8'h07, "sp mid reset");
        check(programStatusWord, 8'h00, "psw mid reset");
        $display("reset done");
        complete_run;
    end
endmodule // mmd_decoder_tb
`default_nettype wire
